/* ttt_regs.vh */
// Purpose: Constants for the tick timer and tone output block
// Assumes: 20 MHz pclk, APB3 register access, 32-bit data
// Notes: Divisor figures are powers of two of pclk
//
// Overview of operation
// - First tick pulse comes on the first falling edge of the chosen tap.
// - The shared divider is never cleared by software; first tick may be early.
// - One control write may set tick rate and enable together.
// - Tick rate in bits 2..0, tick enable in bit 3; code 010 is fc/2^16.
// - Tick codes 000..111 rise from 2.38 Hz to 39063 Hz; prescale halves.
// - Enabled tone output is a square wave of about half duty.
// - Tone enable is control bit 7; one enables, zero disables.
// - Tone codes 00..11 give fc/2^13..fc/2^10; prescale doubles divisors.
`ifndef TTT_REGS_VH
`define TTT_REGS_VH

`define TTT_ADDR_W 12
`define TTT_OFS_CTRL 12'h000
`define TTT_OFS_PRESC 12'h004
`define TTT_OFS_STAT 12'h008

`define TTT_CTRL_RST 8'h00
`define TTT_PRESC_RST 1'b0
`define TTT_TONE_IDLE 1'b1

`define TTT_TICK_SEL_LSB 0
`define TTT_TICK_SEL_MSB 2
`define TTT_TICK_EN_BIT 3
`define TTT_RSVD_BIT 4
`define TTT_TONE_SEL_LSB 5
`define TTT_TONE_SEL_MSB 6
`define TTT_TONE_EN_BIT 7

`define TTT_DIV_W 24

`define TTT_TICK_EXP0 5'h17
`define TTT_TICK_EXP1 5'h15
`define TTT_TICK_EXP2 5'h10
`define TTT_TICK_EXP3 5'h0E
`define TTT_TICK_EXP4 5'h0D
`define TTT_TICK_EXP5 5'h0C
`define TTT_TICK_EXP6 5'h0B
`define TTT_TICK_EXP7 5'h09

`define TTT_TONE_EXP0 5'h0D
`define TTT_TONE_EXP1 5'h0C
`define TTT_TONE_EXP2 5'h0B
`define TTT_TONE_EXP3 5'h0A

`endif

/* ttt_divider.v */
// Purpose: Free-running binary divider shared by tick and tone
// Assumes: Cleared only by reset
// Notes: wrap_o[k] is high in the cycle before bit k falls
`timescale 1ns/1ps
`default_nettype none
module ttt_divider #(
  parameter W = 24
) (
  input wire pclk,
  input wire presetn,
  output reg [W-1:0] cnt_ff,
  output wire [W-1:0] wrap_o
);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= {W{1'b0}};
    end else begin
      cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign wrap_o[0] = cnt_ff[0];

  // Bit k falls when bits k..0 are all ones
  genvar k;
  generate
    for (k = 1; k < W; k = k + 1) begin : g_wrap
      assign wrap_o[k] = wrap_o[k-1] & cnt_ff[k];
    end
  endgenerate

endmodule // ttt_divider
`default_nettype wire

/* ttt_top.v */
// Purpose: Periodic tick pulse and square-wave tone from one divider
// Assumes: APB3 slave, zero wait states, single pclk domain
// Notes: Tone pin idles high while tone output is disabled
`timescale 1ns/1ps
`default_nettype none
`include "ttt_regs.vh"
module ttt_top #(
  parameter DIV_W = `TTT_DIV_W
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`TTT_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg tick_interrupt,
  output reg tone_out_pin
);

  wire [DIV_W-1:0] div_cnt;
  wire [DIV_W-1:0] div_wrap;

  reg [7:0] tick_tone_control_ff;
  reg [7:0] nxt_tick_tone_control;
  reg prescale_halve_select_ff;
  reg nxt_prescale_halve_select;
  reg [7:0] tick_count_ff;
  reg [4:0] tick_exp;
  reg [4:0] tone_exp;
  reg [4:0] tick_tap;
  reg [4:0] tone_tap;
  reg [31:0] nxt_prdata;
  reg nxt_tick_interrupt;
  reg [7:0] nxt_tick_count;
  reg nxt_tone_out_pin;

  wire [2:0] tick_rate_select;
  wire tick_timer_enable;
  wire [1:0] tone_rate_select;
  wire tone_out_enable;
  wire setup_phase;
  wire access_wr;
  wire addr_hit;
  wire tick_fall;
  wire tone_level;

  // Free-running divider, no software clear
  // Shared by tick and tone, so both keep a fixed phase relation
  ttt_divider #(
    .W(DIV_W)
  ) ttt_divider_inst (
    .pclk(pclk),
    .presetn(presetn),
    .cnt_ff(div_cnt),
    .wrap_o(div_wrap)
  );

  assign tick_rate_select =
    tick_tone_control_ff[`TTT_TICK_SEL_MSB:`TTT_TICK_SEL_LSB];
  assign tick_timer_enable = tick_tone_control_ff[`TTT_TICK_EN_BIT];
  assign tone_rate_select =
    tick_tone_control_ff[`TTT_TONE_SEL_MSB:`TTT_TONE_SEL_LSB];
  assign tone_out_enable = tick_tone_control_ff[`TTT_TONE_EN_BIT];

  // APB decode; always ready, unmapped address answers with an error
  assign setup_phase = psel & ~penable;
  assign access_wr = psel & penable & pwrite;
  // Writes to status are dropped without an error
  assign addr_hit = (paddr == `TTT_OFS_CTRL) |
                    (paddr == `TTT_OFS_PRESC) |
                    (paddr == `TTT_OFS_STAT);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  always @* begin
    case (tick_rate_select)
      3'h0: tick_exp = `TTT_TICK_EXP0;
      3'h1: tick_exp = `TTT_TICK_EXP1;
      3'h2: tick_exp = `TTT_TICK_EXP2;
      3'h3: tick_exp = `TTT_TICK_EXP3;
      3'h4: tick_exp = `TTT_TICK_EXP4;
      3'h5: tick_exp = `TTT_TICK_EXP5;
      3'h6: tick_exp = `TTT_TICK_EXP6;
      default: tick_exp = `TTT_TICK_EXP7;
    endcase
  end

  always @* begin
    case (tone_rate_select)
      2'h0: tone_exp = `TTT_TONE_EXP0;
      2'h1: tone_exp = `TTT_TONE_EXP1;
      2'h2: tone_exp = `TTT_TONE_EXP2;
      default: tone_exp = `TTT_TONE_EXP3;
    endcase
  end

  // prescale doubles the divisor
  // A divisor of 2^n is divider bit n-1, whose period is 2^n cycles.
  always @* begin
    tick_tap = tick_exp + {4'h0, prescale_halve_select_ff} - 5'h01;
  end

  // prescale doubles the tone divisor too
  always @* begin
    tone_tap = tone_exp + {4'h0, prescale_halve_select_ff} - 5'h01;
  end

  // edge found from the live select, so a combined write works
  // The fall is decoded from the count itself, not from a stored copy of
  // the old tap, so a select change cannot fake an edge.
  // Rate changes while enabled are not blocked; a short period may follow.
  assign tick_fall = div_wrap[tick_tap];
  // divider bit is an exact half-duty square wave
  assign tone_level = div_cnt[tone_tap];

  // Control register write
  always @* begin
    nxt_tick_tone_control = tick_tone_control_ff;
    if (access_wr && paddr == `TTT_OFS_CTRL) begin
      // bit 4 is not stored and reads as zero
      nxt_tick_tone_control = pwdata[7:0];
      nxt_tick_tone_control[`TTT_RSVD_BIT] = 1'b0;
    end
  end

  // Prescale write; the taps follow it on the next decode
  always @* begin
    nxt_prescale_halve_select = prescale_halve_select_ff;
    if (access_wr && paddr == `TTT_OFS_PRESC) begin
      nxt_prescale_halve_select = pwdata[0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_tone_control_ff <= `TTT_CTRL_RST;
    end else begin
      tick_tone_control_ff <= nxt_tick_tone_control;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_halve_select_ff <= `TTT_PRESC_RST;
    end else begin
      prescale_halve_select_ff <= nxt_prescale_halve_select;
    end
  end

  // Next values of the event outputs
  always @* begin
    nxt_tick_interrupt = tick_timer_enable & tick_fall;
    // Tick count wraps at 256; software takes differences
    nxt_tick_count = tick_count_ff;
    if (tick_timer_enable && tick_fall) begin
      nxt_tick_count = tick_count_ff + 8'h01;
    end
    nxt_tone_out_pin = `TTT_TONE_IDLE;
    if (tone_out_enable) begin
      nxt_tone_out_pin = tone_level;
    end
  end

  // Tick pulse: one cycle, aligned with the tap going low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_interrupt <= 1'b0;
      tick_count_ff <= 8'h00;
    end else begin
      tick_interrupt <= nxt_tick_interrupt;
      tick_count_ff <= nxt_tick_count;
    end
  end

  // Tone pin from a flop so it cannot glitch on select decode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_out_pin <= `TTT_TONE_IDLE;
    end else begin
      tone_out_pin <= nxt_tone_out_pin;
    end
  end

  // Read data captured in setup so it is stable through access
  always @* begin
    nxt_prdata = prdata;
    if (setup_phase) begin
      case (paddr)
        `TTT_OFS_CTRL: nxt_prdata = {24'h000000, tick_tone_control_ff};
        `TTT_OFS_PRESC: nxt_prdata = {31'h00000000, prescale_halve_select_ff};
        `TTT_OFS_STAT: nxt_prdata = {16'h0000, tick_count_ff, 7'h00,
                                     tone_out_pin};
        // Unmapped reads return zero next to the error
        default: nxt_prdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= nxt_prdata;
    end
  end

endmodule // ttt_top
`default_nettype wire

/* ttt_properties.sv */
// Purpose: port checker for ttt_top. Assumes: one pclk domain. Notes: bound.
`timescale 1ns/1ps
`default_nettype none
module ttt_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tick_interrupt,
  input wire logic tone_out_pin
);
  localparam int TX [8] = '{23, 21, 16, 14, 13, 12, 11, 9};
  logic [7:0] ctl_ff;
  logic pre_ff, en_ff, ton_ff, pin_ff, tv_ff;
  logic [1:0] hv_ff;
  logic [24:0] tg_ff, hg_ff;
  wire wr = psel && penable && pwrite;
  wire tog = tone_out_pin != pin_ff;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Any write drops the gap flags: the first gap after it may be short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= 8'h00;
      pre_ff <= 1'b0;
      en_ff <= 1'b0;
      ton_ff <= 1'b0;
      pin_ff <= 1'b1;
      tv_ff <= 1'b0;
      hv_ff <= 2'h0;
      tg_ff <= 25'h0;
      hg_ff <= 25'h0;
    end else begin
      if (wr && paddr == 12'h000) ctl_ff <= pwdata[7:0] & 8'hEF;
      if (wr && paddr == 12'h004) pre_ff <= pwdata[0];
      en_ff <= ctl_ff[3];
      ton_ff <= ctl_ff[7];
      pin_ff <= tone_out_pin;
      tg_ff <= tick_interrupt ? 25'h1 : tg_ff + 25'h1;
      hg_ff <= tog ? 25'h1 : hg_ff + 25'h1;
      tv_ff <= !wr && (tick_interrupt || tv_ff);
      hv_ff <= wr ? 2'h0 : hv_ff + 2'(tog && hv_ff != 2'h2);
    end
  end
  a_tick_pulse: assert property (tick_interrupt |=> !tick_interrupt)
    else $error("tick pulse too long");
  a_tick_off: assert property (!ctl_ff[3] && !en_ff
    |-> !tick_interrupt) else $error("tick while disabled");
  a_tone_idle: assert property (!ctl_ff[7] && !ton_ff
    |-> tone_out_pin) else $error("tone pin not idle");
  a_tick_period: assert property (tick_interrupt && tv_ff |->
    tg_ff == 25'h1 << (TX[ctl_ff[2:0]] + pre_ff)) else $error("tick period");
  a_tone_half: assert property (tog && hv_ff == 2'h2 && ton_ff |->
    hg_ff == 25'h1 << (12 - ctl_ff[6:5] + pre_ff)) else $error("tone half");
  a_slv_err: assert property (psel && penable |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008})) else $error("err");
  a_ctrl_read: assert property (psel && penable && !pwrite
    && paddr == 12'h000 |-> prdata == {24'h0, ctl_ff})
    else $error("control read");
  a_ready_tied: assert property (pready) else $error("pready low");
endmodule // ttt_properties
bind ttt_top ttt_properties ttt_properties_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .tick_interrupt, .tone_out_pin);
`default_nettype wire

/* ttt_buzzer.sv */
// Purpose: buzzer model timing pin levels. Assumes: pclk. Notes: no load.
`timescale 1ns/1ps
`default_nettype none
module ttt_buzzer (
  input wire logic pclk,
  input wire logic pin,
  output wire logic [15:0] hi_len,
  output wire logic [15:0] lo_len
);
  logic [15:0] run_ff = 16'h0000, hi_ff = 16'h0000, lo_ff = 16'h0000;
  logic last_ff = 1'b1;
  assign hi_len = hi_ff;
  assign lo_len = lo_ff;
  always @(posedge pclk) begin
    if (pin !== last_ff) begin
      if (last_ff) hi_ff <= run_ff;
      else lo_ff <= run_ff;
      run_ff <= 16'h0001;
    end else run_ff <= run_ff + 16'h0001;
    last_ff <= pin;
  end
endmodule // ttt_buzzer
`default_nettype wire

/* ttt_top_tb.sv */
// Purpose: bench for ttt_top. Assumes: APB master. Notes: fast tick codes only.
`timescale 1ns/1ps
`default_nettype none
module ttt_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pre;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] cv;
  logic [32:0] exq [$];
  wire [31:0] prdata;
  wire pready, pslverr, tick_interrupt, tone_out_pin;
  wire [15:0] hi_len, lo_len;
  int miscompares = 0, n_compared = 0, hp, tk = 0, tp = 0;
  integer seed = 32'hA45B;
  always #25 pclk = ~pclk;
  ttt_top ttt_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tick_interrupt, .tone_out_pin);
  ttt_buzzer ttt_buzzer_inst (.pclk, .pin(tone_out_pin), .hi_len, .lo_len);
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    exq.push_back(e);
    apb(0, a, $random(seed));
  endtask
  task fail(input string m);
    miscompares++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) fail(m);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exq.size() > 0) begin
      n_compared++;
      if ({pslverr, prdata} !== exq.pop_front()) fail("read data");
    end
  end
  // Cycles between tick pulses, for the period checks
  always @(posedge pclk) begin
    if (tick_interrupt === 1'b1) begin
      tp <= tk + 1;
      tk <= 0;
    end else begin
      tk <= tk + 1;
    end
  end
  task results;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #5000000;
    fail("timeout");
    results;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    rd(12'h000, 33'h0);
    rd(12'h008, 33'h1);
    rd(12'h00C, 33'h100000000);
    $display("test reset done");
    // Upper bits random; bit 4 kept zero as software must
    apb(1, 12'h000, 32'hEF | ($random(seed) & 32'hFFFFFF00));
    apb(1, 12'h010, 32'h0);
    rd(12'h000, 33'hEF);
    repeat (2000) @(posedge pclk);
    chk(hi_len === 16'h0200 && lo_len === 16'h0200, "duty");
    chk(tp == 512, "tick period");
    $display("test duty done");
    cv = 8'hEF;
    for (int c = 0; c < 4; c++) begin
      // Disable first with fields kept, then select and enable at once
      apb(1, 12'h000, {24'h0, cv & 8'h67});
      pre = 1'($random(seed));
      apb(1, 12'h004, {31'h0, pre});
      cv = {1'b1, c[1:0], 1'b0, 1'b1, 3'(4 + c)};
      apb(1, 12'h000, {24'h0, cv});
      hp = 1 << (12 - c + pre);
      repeat (hp * 5) @(posedge pclk);
      chk(hi_len === 16'(hp) && lo_len === 16'(hp), "half");
      hp = 1 << ((c == 3 ? 9 : 13 - c) + pre);
      chk(tp == hp, "tick period");
      $display("test rate %0d done", c);
    end
    apb(1, 12'h000, {24'h0, cv & 8'h67});
    repeat (4) @(posedge pclk);
    chk(tone_out_pin === 1'b1, "tone idle");
    rd(12'h004, {32'h0, pre});
    results;
  end
endmodule // ttt_top_tb
`default_nettype wire
